/* File: logic/dacrz_params.svh */
/*
 * constants for the dac reset and zero-detect housekeeping block.
 * assumes inclusion by bare name from the design files under logic/.
 */
`ifndef DACRZ_PARAMS_SVH
`define DACRZ_PARAMS_SVH

// ------------------------------------------------------------------
// register map (word index = byte address / 4 not used: plain port)
// ------------------------------------------------------------------
`define DACRZ_ADDR_W 8
`define DACRZ_REG_ZCTRL 8'h16
`define DACRZ_REG_FMT 8'h17
`define DACRZ_REG_STATUS 8'h18
`define DACRZ_REG_RATIO 8'h19
// control register 22 fields
`define DACRZ_BIT_COMBO 0
`define DACRZ_BIT_POL 1
`define DACRZ_BIT_PINSEL 2
`define DACRZ_ZCTRL_RST 8'h00
// format register fields
`define DACRZ_FMT_LSB 0
`define DACRZ_LEN_LSB 2
`define DACRZ_FMT_RST 8'h00
// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define DACRZ_INIT_CYCLES 3846
`define DACRZ_INIT_W 12
`define DACRZ_ZERO_FRAMES 1024
`define DACRZ_ZCNT_W 11
`define DACRZ_WORD_W 32
`define DACRZ_BCNT_W 6
`define DACRZ_SCNT_W 12
// sysclk per frame: 128..1152 fs, with slack for jitter
`define DACRZ_RATIO_MIN 12'd0120
`define DACRZ_RATIO_MAX 12'd1160

`endif

/* File: logic/dacrz_pkg.sv */
/*
 * types shared by the housekeeping block.
 * assumes nothing of its surroundings.
 */
package dacrz_pkg;
    typedef enum logic [1:0] {DACRZ_FMT_I2S, DACRZ_FMT_LJ, DACRZ_FMT_RJ, DACRZ_FMT_DSP}
        dacrz_fmt_type;
    typedef enum logic [1:0] {DACRZ_LEN_16, DACRZ_LEN_20, DACRZ_LEN_24, DACRZ_LEN_32}
        dacrz_len_type;
    typedef enum logic [1:0] {DACRZ_OUT_GND, DACRZ_OUT_MID, DACRZ_OUT_DATA} dacrz_out_type;
endpackage

/* File: logic/dacrz_zero_chan.sv */
/*
 * per-channel zero-run counter.
 * assumes a one-cycle frame strobe and sample-valid strobe on ref_clk.
 */
`timescale 1ns/1ps
`include "dacrz_params.svh"

module dacrz_zero_chan
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic smp_valid,
    input wire logic smp_zero,
    input wire logic frame_tick,
    output logic zero_run
);
    logic [`DACRZ_ZCNT_W-1:0] cnt_r;
    logic seen_one_r;

    // a one bit anywhere in the frame restarts the run at once
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            seen_one_r <= 1'b0;
        else if (clr || frame_tick)
            seen_one_r <= 1'b0;
        else if (smp_valid && !smp_zero)
            seen_one_r <= 1'b1;
    end

    // saturating count of whole zero frames
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_r <= '0;
        else if (clr || (smp_valid && !smp_zero))
            cnt_r <= '0;
        else if (frame_tick && !seen_one_r && cnt_r != `DACRZ_ZCNT_W'(`DACRZ_ZERO_FRAMES))
            cnt_r <= cnt_r + `DACRZ_ZCNT_W'(1);
    end

    assign zero_run = (cnt_r == `DACRZ_ZCNT_W'(`DACRZ_ZERO_FRAMES));

    a_run_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (smp_valid && !smp_zero) |=> !zero_run)
        else $error("zero run not cleared by a nonzero sample");
endmodule

/* File: logic/dacrz_top.sv */
/*
 * reset sequencing, clock-sync watch, output mute state and zero flags
 * of a stereo audio dac.
 * assumes the audio pins arrive asynchronous to ref_clk (200 MHz) and
 * that ref_clk is at least four times the bit clock.
 */
`timescale 1ns/1ps
`include "dacrz_params.svh"

// Behaviour
// - internal reset releases 3846 sysclk cycles after power-on with pin high.
// - during initialisation both outputs sit at mid supply.
// - clocks out of sync keep reset and power-down; resync re-runs the sequence.
// - reset pin falling in sync resets registers and powers down fully.
// - at external reset the outputs go to analog ground at once.
// - reset pin rising repeats the whole 3846-cycle start-up.
// - combination select bit in register 22 sets what each flag watches.
// - flag sets after 1024 all-zero frames on every assigned channel, or on either one for the combo B first flag.
// - flag clears immediately when an assigned channel carries a one, the combo B first flag only once neither channel is in a zero run.
// - zero detect works for 16, 20, 24 bits, never for 32.
// - a polarity bit inverts the flags; reset default is active high.
// - hardware control mode forces combination A.
// - 16..32 bit words in i2s and lj, only 24 bit in rj and dsp.
// - samples are msb-first twos complement.
// - frame rates from 8 kHz to 192 kHz are accepted.
// - control is by the plain register port or by hw_mode pin strapping.
// - combo A left/right; combo B either-zero and both-zero.
// - after reset the shared pin carries the second zero flag.
module dacrz_top
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic system_clock_in,
    input wire logic serial_bit_clock,
    input wire logic frame_clock_in,
    input wire logic serial_data_in,
    input wire logic reset_n_pin,
    input wire logic hw_mode,
    input wire logic mute_status_in,
    input wire logic [`DACRZ_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic int_reset,
    output logic power_down,
    output dacrz_pkg::dacrz_out_type analog_out_pair,
    output logic [23:0] sample_left,
    output logic [23:0] sample_right,
    output logic sample_strobe,
    output logic first_zero_flag,
    output logic second_zero_flag
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] s1_r;
    logic [4:0] s2_r;
    logic [4:0] s3_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_r <= 5'h18;
            s2_r <= 5'h18;
            s3_r <= 5'h18;
        end
        else
        begin
            s1_r <= {mute_status_in, reset_n_pin, serial_data_in, frame_clock_in,
                     serial_bit_clock};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic sclk_s;
    logic sclk_d;
    logic bck_rise;
    logic lr_s;
    logic din_s;
    logic rstn_s;
    logic rstn_d;
    logic mute_s;
    assign bck_rise = s2_r[0] && !s3_r[0];
    assign lr_s = s2_r[1];
    assign din_s = s2_r[2];
    assign rstn_s = s2_r[3];
    assign rstn_d = s3_r[3];
    assign mute_s = s2_r[4];

    logic sc1_r;
    logic sc2_r;
    logic sc3_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sc1_r <= 1'b0;
            sc2_r <= 1'b0;
            sc3_r <= 1'b0;
        end
        else
        begin
            sc1_r <= system_clock_in;
            sc2_r <= sc1_r;
            sc3_r <= sc2_r;
        end
    end
    assign sclk_s = sc2_r;
    assign sclk_d = sc3_r;
    logic sck_rise;
    assign sck_rise = sclk_s && !sclk_d;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] zctrl_r;
    logic [7:0] fmt_r;
    logic reg_clr;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            zctrl_r <= `DACRZ_ZCTRL_RST;
            fmt_r <= `DACRZ_FMT_RST;
        end
        else if (reg_clr)
        begin
            zctrl_r <= `DACRZ_ZCTRL_RST;
            fmt_r <= `DACRZ_FMT_RST;
        end
        else if (reg_wr && reg_addr == `DACRZ_REG_ZCTRL)
            zctrl_r <= reg_wdata;
        else if (reg_wr && reg_addr == `DACRZ_REG_FMT)
            fmt_r <= reg_wdata;
    end
    dacrz_pkg::dacrz_fmt_type fmt;
    dacrz_pkg::dacrz_len_type len;
    dacrz_pkg::dacrz_len_type len_eff;
    assign fmt = dacrz_pkg::dacrz_fmt_type'(hw_mode ? {1'b0, fmt_r[`DACRZ_FMT_LSB]} :
                                            fmt_r[`DACRZ_FMT_LSB+:2]);
    assign len = dacrz_pkg::dacrz_len_type'(fmt_r[`DACRZ_LEN_LSB+:2]);
    // rj and dsp only carry 24-bit words
    assign len_eff = (fmt == dacrz_pkg::DACRZ_FMT_RJ || fmt == dacrz_pkg::DACRZ_FMT_DSP) ?
                     dacrz_pkg::DACRZ_LEN_24 : len;

    // ------------------------------------------------------------------
    // sync watch: sysclk edges per frame must be a legal ratio
    // ------------------------------------------------------------------
    logic [`DACRZ_SCNT_W-1:0] scnt_r;
    logic [`DACRZ_SCNT_W-1:0] ratio_r;
    logic lr_d_r;
    logic frame_tick;
    logic in_sync_r;
    assign frame_tick = bck_rise && lr_s && !lr_d_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            lr_d_r <= 1'b0;
        else if (bck_rise)
            lr_d_r <= lr_s;
    end
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scnt_r <= '0;
            ratio_r <= '0;
            in_sync_r <= 1'b0;
        end
        else if (frame_tick)
        begin
            scnt_r <= '0;
            ratio_r <= scnt_r;
            in_sync_r <= scnt_r >= `DACRZ_RATIO_MIN && scnt_r <= `DACRZ_RATIO_MAX;
        end
        else if (sck_rise)
        begin
            // a runaway count means a halted frame clock: drop sync now
            if (scnt_r == '1)
                in_sync_r <= 1'b0;
            else
                scnt_r <= scnt_r + `DACRZ_SCNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DACRZ_ST_HELD, DACRZ_ST_INIT, DACRZ_ST_RUN} dacrz_state_type;
    dacrz_state_type st_r;
    logic [`DACRZ_INIT_W-1:0] icnt_r;
    logic ext_fall;
    assign ext_fall = rstn_d && !rstn_s;
    assign reg_clr = ext_fall && in_sync_r;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= DACRZ_ST_INIT;
            icnt_r <= '0;
        end
        else
        begin
            unique case (st_r)
                DACRZ_ST_HELD:
                begin
                    icnt_r <= '0;
                    if (rstn_s)
                        st_r <= DACRZ_ST_INIT;
                end
                DACRZ_ST_INIT:
                begin
                    if (!rstn_s)
                        st_r <= DACRZ_ST_HELD;
                    else if (icnt_r == `DACRZ_INIT_W'(`DACRZ_INIT_CYCLES))
                    begin
                        if (in_sync_r)
                            st_r <= DACRZ_ST_RUN;
                    end
                    else if (sck_rise)
                        icnt_r <= icnt_r + `DACRZ_INIT_W'(1);
                end
                DACRZ_ST_RUN:
                begin
                    icnt_r <= '0;
                    if (!rstn_s)
                        st_r <= DACRZ_ST_HELD;
                    else if (!in_sync_r)
                        st_r <= DACRZ_ST_INIT;
                end
            endcase
        end
    end
    logic running;
    assign running = st_r == DACRZ_ST_RUN;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_reset <= 1'b1;
            power_down <= 1'b1;
            analog_out_pair <= dacrz_pkg::DACRZ_OUT_MID;
        end
        else
        begin
            int_reset <= !running;
            power_down <= !running;
            if (!rstn_s)
                analog_out_pair <= dacrz_pkg::DACRZ_OUT_GND;
            else if (!running || !mute_s)
                analog_out_pair <= dacrz_pkg::DACRZ_OUT_MID;
            else
                analog_out_pair <= dacrz_pkg::DACRZ_OUT_DATA;
        end
    end

    // ------------------------------------------------------------------
    // serial receiver: msb first, left on low frame phase in i2s only, high in lj/rj/dsp
    // ------------------------------------------------------------------
    logic [`DACRZ_WORD_W-1:0] sh_r;
    logic [`DACRZ_BCNT_W-1:0] bcnt_r;
    logic lr_bit_r;
    logic [5:0] wbits;
    always_comb
    begin
        unique case (len_eff)
            dacrz_pkg::DACRZ_LEN_16: wbits = 6'd16;
            dacrz_pkg::DACRZ_LEN_20: wbits = 6'd20;
            dacrz_pkg::DACRZ_LEN_24: wbits = 6'd24;
            dacrz_pkg::DACRZ_LEN_32: wbits = 6'd32;
        endcase
    end
    logic phase_edge;
    logic word_done;
    assign phase_edge = bck_rise && (lr_s != lr_d_r);
    // words of every format end after wbits bits; the phase edge never ends a word
    assign word_done = bck_rise && !phase_edge && bcnt_r == wbits;
    logic [23:0] word24;
    // left-aligned msb-first word, sign in bit 23 except 32-bit words, which keep their low 24 bits
    assign word24 = sh_r[23:0] << (6'd24 - (wbits > 6'd24 ? 6'd24 : wbits));
    logic smp_valid_l;
    logic smp_valid_r;
    logic smp_zero;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sh_r <= '0;
            bcnt_r <= '0;
            lr_bit_r <= 1'b0;
        end
        else if (bck_rise)
        begin
            sh_r <= {sh_r[`DACRZ_WORD_W-2:0], din_s};
            if (phase_edge)
            begin
                bcnt_r <= (fmt == dacrz_pkg::DACRZ_FMT_I2S) ? '0 : `DACRZ_BCNT_W'(1);
                lr_bit_r <= lr_s;
            end
            else if (bcnt_r != '1)
                bcnt_r <= bcnt_r + `DACRZ_BCNT_W'(1);
        end
    end
    assign smp_valid_l = running && word_done && lr_bit_r == (fmt != dacrz_pkg::DACRZ_FMT_I2S);
    assign smp_valid_r = running && word_done && !smp_valid_l;
    assign smp_zero = word24 == 24'h00_0000;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sample_left <= '0;
            sample_right <= '0;
            sample_strobe <= 1'b0;
        end
        else
        begin
            sample_strobe <= smp_valid_r;
            if (smp_valid_l)
                sample_left <= word24;
            if (smp_valid_r)
                sample_right <= word24;
        end
    end

    // ------------------------------------------------------------------
    // zero detect, one counter per channel
    // ------------------------------------------------------------------
    logic [1:0] zrun;
    logic zclr;
    // 32-bit words never report zero
    assign zclr = !running || len_eff == dacrz_pkg::DACRZ_LEN_32;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            dacrz_zero_chan u_chan
            (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .clr(zclr),
                .smp_valid(ch == 0 ? smp_valid_l : smp_valid_r),
                .smp_zero(smp_zero),
                .frame_tick(frame_tick),
                .zero_run(zrun[ch])
            );
        end
    endgenerate
    logic combo_b;
    logic pol;
    logic z1;
    logic z2;
    assign combo_b = zctrl_r[`DACRZ_BIT_COMBO] && !hw_mode;
    assign pol = zctrl_r[`DACRZ_BIT_POL];
    // combination A per channel, B either / both
    assign z1 = combo_b ? (zrun[0] || zrun[1]) : zrun[0];
    assign z2 = combo_b ? (zrun[0] && zrun[1]) : zrun[1];
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            first_zero_flag <= 1'b0;
            second_zero_flag <= 1'b0;
        end
        else
        begin
            first_zero_flag <= z1 ^ pol;
            if (zctrl_r[`DACRZ_BIT_PINSEL])
                second_zero_flag <= mute_s;
            else
                second_zero_flag <= z2 ^ pol;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `DACRZ_REG_ZCTRL: reg_rdata <= zctrl_r;
                `DACRZ_REG_FMT: reg_rdata <= fmt_r;
                `DACRZ_REG_STATUS: reg_rdata <= {4'h0, zrun, in_sync_r, running};
                `DACRZ_REG_RATIO: reg_rdata <= ratio_r[11:4];
                default: reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_reset_gnd: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !rstn_s |=> analog_out_pair == dacrz_pkg::DACRZ_OUT_GND)
        else $error("outputs not grounded under external reset");
    a_init_mid: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (rstn_s && st_r == DACRZ_ST_INIT) |=> analog_out_pair != dacrz_pkg::DACRZ_OUT_DATA)
        else $error("data driven during initialisation");
    a_release_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_r == DACRZ_ST_INIT && $past(st_r) != DACRZ_ST_INIT) |-> icnt_r == '0)
        else $error("init count not restarted");
    a_release_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ($rose(running)) |-> icnt_r == `DACRZ_INIT_W'(`DACRZ_INIT_CYCLES))
        else $error("released before full start-up count");
    a_sync_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!in_sync_r && st_r != DACRZ_ST_RUN) |=> int_reset && power_down)
        else $error("reset released while out of sync");
    a_reg_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_clr |=> zctrl_r == `DACRZ_ZCTRL_RST && fmt_r == `DACRZ_FMT_RST)
        else $error("registers not cleared at external reset");
    a_no_zero32: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (len_eff == dacrz_pkg::DACRZ_LEN_32) |=> zrun == 2'b00)
        else $error("zero flagged for 32-bit words");
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (smp_valid_l && !smp_zero && !combo_b && !zctrl_r[`DACRZ_BIT_POL] &&
         !(reg_wr && reg_addr == `DACRZ_REG_ZCTRL))
        |=> ##1 !first_zero_flag)
        else $error("first flag not cleared by nonzero left sample");
    a_hw_combo: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hw_mode |-> !combo_b)
        else $error("combination B used in hardware mode");
endmodule

/* File: verif/dacrz_audio_src.sv */
/*
 * audio source model: system clock, bit clock, frame clock, i2s data.
 * assumes 16-bit words in 64-slot frames; the bit clock keeps running
 * while the system clock is halted, so a halt shows as lost sync.
 */
`timescale 1ns/1ps

module dacrz_audio_src
(
    input wire logic run,
    input wire logic [15:0] word_left,
    input wire logic [15:0] word_right,
    output logic system_clock_in,
    output logic serial_bit_clock,
    output logic frame_clock_in,
    output logic serial_data_in
);
    logic [1:0] tick_r;
    logic [5:0] slot_r;
    logic [15:0] word;
    int k;

    // sysclk 20 ns, bit clock 80 ns: 256 sysclk per frame
    initial
    begin
        system_clock_in = 1'b0;
        serial_bit_clock = 1'b0;
        frame_clock_in = 1'b1;
        serial_data_in = 1'b0;
        tick_r = 2'h0;
        slot_r = 6'h3f;
        #3.7;
        forever
        begin
            #10;
            if (run)
                system_clock_in = ~system_clock_in;
            tick_r = tick_r + 2'h1;
            if (tick_r == 2'h0)
            begin
                serial_bit_clock = ~serial_bit_clock;
                // data moves on the falling edge, away from the sampling edge
                if (!serial_bit_clock)
                begin
                    slot_r = slot_r + 6'h01;
                    frame_clock_in = slot_r[5];
                    word = slot_r[5] ? word_right : word_left;
                    k = int'(slot_r[4:0]);
                    serial_data_in = (k >= 1 && k <= 16) ? word[16 - k] : 1'b0;
                end
            end
        end
    end
endmodule

/* File: verif/dac_reset_and_zero_detect_test.sv */
/*
 * self-checking bench for the dac reset and zero-detect block.
 * assumes the audio source model and the design files under logic/.
 */
`timescale 1ns/1ps
`include "dacrz_params.svh"

module dac_reset_and_zero_detect_test;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_n_pin = 1'b1;
    logic mute_status_in = 1'b1;
    logic [`DACRZ_ADDR_W-1:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b1;
    logic hw_mode = 1'b0;
    logic [15:0] word_left = 16'h0000;
    logic [15:0] word_right = 16'h0000;
    logic system_clock_in, serial_bit_clock, frame_clock_in, serial_data_in;
    logic [7:0] reg_rdata, rd;
    logic int_reset, power_down, sample_strobe, first_zero_flag, second_zero_flag;
    logic [23:0] sample_left, sample_right;
    dacrz_pkg::dacrz_out_type analog_out_pair;
    int bad_count = 0;
    int n_tests = 0;

    always #2.5 ref_clk = ~ref_clk;

    dacrz_audio_src source (.run(run), .word_left(word_left), .word_right(word_right),
        .system_clock_in(system_clock_in), .serial_bit_clock(serial_bit_clock),
        .frame_clock_in(frame_clock_in), .serial_data_in(serial_data_in));

    dacrz_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .system_clock_in(system_clock_in),
        .serial_bit_clock(serial_bit_clock), .frame_clock_in(frame_clock_in),
        .serial_data_in(serial_data_in), .reset_n_pin(reset_n_pin), .hw_mode(hw_mode),
        .mute_status_in(mute_status_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_reset(int_reset),
        .power_down(power_down), .analog_out_pair(analog_out_pair),
        .sample_left(sample_left), .sample_right(sample_right),
        .sample_strobe(sample_strobe), .first_zero_flag(first_zero_flag),
        .second_zero_flag(second_zero_flag));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task automatic wait_strobe();
        for (int i = 0; i < 1500 && sample_strobe !== 1'b1; i++)
            cyc(1);
        check("strobe seen", sample_strobe, 1);
        cyc(1);
    endtask

    // 3846 sysclk edges are 15384 ref_clk cycles; 14000 is safely short
    task automatic expect_startup();
        cyc(14000);
        check("int_reset held", int_reset, 1);
        check("init output", analog_out_pair, dacrz_pkg::DACRZ_OUT_MID);
        for (int i = 0; i < 4000 && int_reset !== 1'b0; i++)
            cyc(1);
        cyc(2);
        check("int_reset freed", int_reset, 0);
        check("power_down freed", power_down, 0);
        check("run output", analog_out_pair, dacrz_pkg::DACRZ_OUT_DATA);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        reg_read(`DACRZ_REG_ZCTRL, rd);
        check("zctrl reset", rd, `DACRZ_ZCTRL_RST);
        reg_read(`DACRZ_REG_FMT, rd);
        check("fmt reset", rd, `DACRZ_FMT_RST);
        reg_write(8'h40, 8'hff);
        reg_read(8'h40, rd);
        check("unmapped read", rd, 8'h00);
        // hardware mode with combination b and 32-bit words requested
        reg_write(`DACRZ_REG_ZCTRL, 8'h01);
        hw_mode <= 1'b1;
        reg_write(`DACRZ_REG_FMT, 8'h0c);
        reg_read(`DACRZ_REG_FMT, rd);
        check("fmt back", rd, 8'h0c);
        reg_read(`DACRZ_REG_ZCTRL, rd);
        check("zctrl combo", rd, 8'h01);
        cyc(1);
        hw_mode <= 1'b0;
        reg_write(`DACRZ_REG_ZCTRL, 8'h00);
        reg_write(`DACRZ_REG_FMT, 8'h00);
    endtask

    task automatic test_samples();
        word_left <= 16'h8001;
        word_right <= 16'h7ffe;
        wait_strobe();
        check("strobe width", sample_strobe, 0);
        wait_strobe();
        check("left word", sample_left, {16'h8001, 8'h00});
        check("right word", sample_right, {16'h7ffe, 8'h00});
        check("flag1 nonzero", first_zero_flag, 0);
        check("flag2 nonzero", second_zero_flag, 0);
    endtask

    // mute low first, so a pin wrongly showing mute status reads 0
    task automatic test_flag_pins();
        mute_status_in <= 1'b0;
        reg_write(`DACRZ_REG_ZCTRL, 8'h02);
        reg_read(`DACRZ_REG_ZCTRL, rd);
        check("zctrl back", rd, 8'h02);
        cyc(4);
        check("flag1 inverted", first_zero_flag, 1);
        check("pin carries flag2", second_zero_flag, 1);
        check("muted output", analog_out_pair, dacrz_pkg::DACRZ_OUT_MID);
        reg_write(`DACRZ_REG_ZCTRL, 8'h04);
        cyc(4);
        check("pin shows mute", second_zero_flag, 0);
        check("flag1 active high", first_zero_flag, 0);
        mute_status_in <= 1'b1;
        cyc(4);
        check("pin shows unmute", second_zero_flag, 1);
        reg_write(`DACRZ_REG_ZCTRL, 8'h00);
        cyc(4);
        check("flag2 restored", second_zero_flag, 0);
    endtask

    task automatic test_ext_reset();
        reg_write(`DACRZ_REG_ZCTRL, 8'h02);
        reset_n_pin <= 1'b0;
        cyc(5);
        check("pin output", analog_out_pair, dacrz_pkg::DACRZ_OUT_GND);
        check("pin int_reset", int_reset, 1);
        check("pin power_down", power_down, 1);
        reg_read(`DACRZ_REG_ZCTRL, rd);
        check("zctrl cleared", rd, 8'h00);
        check("flag1 cleared", first_zero_flag, 0);
        reset_n_pin <= 1'b1;
        expect_startup();
    endtask

    task automatic test_sync_loss();
        run <= 1'b0;
        cyc(2500);
        check("unsynced int_reset", int_reset, 1);
        check("unsynced power_down", power_down, 1);
        reg_read(`DACRZ_REG_STATUS, rd);
        check("status unsynced", rd & 8'h03, 8'h00);
        run <= 1'b1;
        expect_startup();
        reg_read(`DACRZ_REG_STATUS, rd);
        check("status synced", rd & 8'h03, 8'h03);
    endtask

    initial
    begin
        cyc(8);
        check("reset int_reset", int_reset, 1);
        check("reset power_down", power_down, 1);
        check("reset output", analog_out_pair, dacrz_pkg::DACRZ_OUT_MID);
        check("reset flag1", first_zero_flag, 0);
        sys_rst <= 1'b0;
        test_regs();
        expect_startup();
        test_samples();
        test_flag_pins();
        test_ext_reset();
        test_sync_loss();
        summarize();
    end

    // about 52k cycles expected; 90k cuts a hang short
    initial
    begin
        #450000;
        bad_count++;
        summarize();
    end
endmodule
